// ### core/tap_shift_reg.sv
// Capture/shift register used for the instruction and boundary chains.
// Assumes strobes are one-cycle pulses on i_clk, already qualified.
module tap_shift_reg #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Control strobes
  input wire logic i_capture,
  input wire logic i_shift,
  // Data
  input wire logic [W-1:0] i_capture_data,
  input wire logic i_serial_in,
  output logic o_serial_out,
  output logic [W-1:0] o_par
);

  if (W < 1) begin : g_bad_w
    $error("tap_shift_reg needs W of at least 1");
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_par <= '0;
    end else if (i_capture) begin
      o_par <= i_capture_data;
    end else if (i_shift) begin
      // Shifts toward bit 0, which is the serial output
      if (W == 1) begin
        o_par <= i_serial_in;
      end else begin
        o_par <= {i_serial_in, o_par[W-1:1]};
      end
    end
  end

  assign o_serial_out = o_par[0];

endmodule

// ### core/test_port_and_reset_entry.sv
// Test access port pins, TAP routing, pull-up control and reset entry.
// Assumes all pins are asynchronous to i_clk; test clock far slower
// than i_clk so each of its edges is seen after synchronisation.
`include "test_port_map.svh"

module test_port_and_reset_entry #(
  parameter int IR_W = 4,
  parameter int BSR_W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Device reset pin, active low
  input wire logic i_reset_pin_n,
  // Scan pins
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_test_rst_n,
  input wire logic i_emulation_select_pin,
  output logic o_tdo,
  output logic o_tdo_oe_n,
  // Pull-up control
  input wire logic [`TP_PUI_W-1:0] i_pullup_inhibit_reg,
  output logic o_pu_reset_en,
  output logic o_pu_tms_en,
  output logic o_pu_tdi_en,
  output logic o_pu_tck_en,
  // Boundary register connection
  input wire logic [BSR_W-1:0] i_bsr_capture,
  output logic [BSR_W-1:0] o_bsr_update,
  // Emulation tap connection
  output logic o_emu_selected,
  output logic o_emu_tck_rise,
  output logic o_emu_tck_fall,
  output logic o_emu_tms,
  output logic o_emu_tdi,
  input wire logic i_emu_tdo,
  input wire logic i_emu_tdo_drive,
  // Scan state
  output logic o_scan_active,
  output logic [IR_W-1:0] o_instruction,
  // Core control
  output logic o_cpu_halt,
  output logic o_vector_rd,
  output logic [`TP_PC_W-1:0] o_vector_addr,
  input wire logic [`TP_PC_W-1:0] i_rom_vector,
  output logic [`TP_PC_W-1:0] o_pc,
  output logic o_pc_load,
  output logic o_boot_branch
);

  if (IR_W < 2) begin : g_bad_ir
    $error("IR_W must be at least 2");
  end
  if (BSR_W < 1) begin : g_bad_bsr
    $error("BSR_W must be at least 1");
  end

  // Two-stage synchronisers for every pin; edge history reads only the second stage
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic tck_s, tms_s, tdi_s, trst_n_s, emu_sel_s, reset_n_s;
  logic tck_d, trst_n_d, tck_rise, tck_fall, trst_release;
  assign {reset_n_s, emu_sel_s, trst_n_s, tdi_s, tms_s, tck_s} = pin_sync;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
      tck_d <= 1'b0;
      trst_n_d <= 1'b0;
    end else begin
      pin_meta <= {i_reset_pin_n, i_emulation_select_pin, i_test_rst_n, i_tdi, i_tms, i_tck};
      pin_sync <= pin_meta;
      tck_d <= tck_s;
      trst_n_d <= trst_n_s;
    end
  end

  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;
  assign trst_release = trst_n_s & ~trst_n_d;

  // Tap choice, caught only on a low-then-high test reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_emu_selected <= 1'b0;
    end else if (trst_release) begin
      o_emu_selected <= emu_sel_s;
    end
  end

  // Boundary-scan tap is live only with test reset high and not routed away
  logic bs_live;
  assign bs_live = trst_n_s & ~o_emu_selected;

  test_port_pkg::tap_state_e state, next_state;

  always_comb begin
    next_state = state;
    case (state)
      test_port_pkg::TLR: next_state = tms_s ? test_port_pkg::TLR : test_port_pkg::RTI;
      test_port_pkg::RTI: next_state = tms_s ? test_port_pkg::SEL_DR : test_port_pkg::RTI;
      test_port_pkg::SEL_DR: next_state = tms_s ? test_port_pkg::SEL_IR : test_port_pkg::CAP_DR;
      test_port_pkg::CAP_DR: next_state = tms_s ? test_port_pkg::EXIT1_DR : test_port_pkg::SHIFT_DR;
      test_port_pkg::SHIFT_DR: next_state = tms_s ? test_port_pkg::EXIT1_DR : test_port_pkg::SHIFT_DR;
      test_port_pkg::EXIT1_DR: next_state = tms_s ? test_port_pkg::UPD_DR : test_port_pkg::PAUSE_DR;
      test_port_pkg::PAUSE_DR: next_state = tms_s ? test_port_pkg::EXIT2_DR : test_port_pkg::PAUSE_DR;
      test_port_pkg::EXIT2_DR: next_state = tms_s ? test_port_pkg::UPD_DR : test_port_pkg::SHIFT_DR;
      test_port_pkg::UPD_DR: next_state = tms_s ? test_port_pkg::SEL_DR : test_port_pkg::RTI;
      test_port_pkg::SEL_IR: next_state = tms_s ? test_port_pkg::TLR : test_port_pkg::CAP_IR;
      test_port_pkg::CAP_IR: next_state = tms_s ? test_port_pkg::EXIT1_IR : test_port_pkg::SHIFT_IR;
      test_port_pkg::SHIFT_IR: next_state = tms_s ? test_port_pkg::EXIT1_IR : test_port_pkg::SHIFT_IR;
      test_port_pkg::EXIT1_IR: next_state = tms_s ? test_port_pkg::UPD_IR : test_port_pkg::PAUSE_IR;
      test_port_pkg::PAUSE_IR: next_state = tms_s ? test_port_pkg::EXIT2_IR : test_port_pkg::PAUSE_IR;
      test_port_pkg::EXIT2_IR: next_state = tms_s ? test_port_pkg::UPD_IR : test_port_pkg::SHIFT_IR;
      test_port_pkg::UPD_IR: next_state = tms_s ? test_port_pkg::SEL_DR : test_port_pkg::RTI;
      default: next_state = test_port_pkg::TLR;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= test_port_pkg::TLR;
    end else if (!bs_live) begin
      state <= test_port_pkg::TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // Register actions, all on the rising test clock
  logic act, boundary_sel;
  assign act = bs_live & tck_rise;
  assign boundary_sel = (o_instruction == IR_W'(`TP_IR_BOUNDARY));

  logic ir_so, bsr_so;
  logic [IR_W-1:0] ir_par;
  logic [BSR_W-1:0] bsr_par;

  tap_shift_reg #(.W(IR_W)) u_ir (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_capture(act && state == test_port_pkg::CAP_IR),
    .i_shift(act && state == test_port_pkg::SHIFT_IR),
    .i_capture_data({{(IR_W-2){1'b0}}, `TP_IR_CAPTURE_LOW}),
    .i_serial_in(tdi_s),
    .o_serial_out(ir_so),
    .o_par(ir_par)
  );

  tap_shift_reg #(.W(BSR_W)) u_bsr (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_capture(act && boundary_sel && state == test_port_pkg::CAP_DR),
    .i_shift(act && boundary_sel && state == test_port_pkg::SHIFT_DR),
    .i_capture_data(i_bsr_capture),
    .i_serial_in(tdi_s),
    .o_serial_out(bsr_so),
    .o_par(bsr_par)
  );

  logic bypass;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bypass <= 1'b0;
    end else if (act && !boundary_sel && state == test_port_pkg::CAP_DR) begin
      bypass <= 1'b0;
    end else if (act && !boundary_sel && state == test_port_pkg::SHIFT_DR) begin
      bypass <= tdi_s;
    end
  end

  // Instruction falls back to bypass whenever the tap is reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_instruction <= '1;
    end else if (!bs_live || state == test_port_pkg::TLR) begin
      o_instruction <= '1;
    end else if (act && state == test_port_pkg::UPD_IR) begin
      o_instruction <= ir_par;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_bsr_update <= '0;
    end else if (act && boundary_sel && state == test_port_pkg::UPD_DR) begin
      o_bsr_update <= bsr_par;
    end
  end

  logic shifting;
  assign shifting = (state == test_port_pkg::SHIFT_IR) || (state == test_port_pkg::SHIFT_DR);

  // Output side moves on the falling test clock; test reset low turns the driver off at once
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tdo <= 1'b0;
      o_tdo_oe_n <= 1'b1;
    end else if (!trst_n_s) begin
      o_tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      if (o_emu_selected) begin
        o_tdo <= i_emu_tdo;
        o_tdo_oe_n <= ~i_emu_tdo_drive;
      end else begin
        if (state == test_port_pkg::SHIFT_IR) begin
          o_tdo <= ir_so;
        end else if (state == test_port_pkg::SHIFT_DR) begin
          o_tdo <= boundary_sel ? bsr_so : bypass;
        end
        o_tdo_oe_n <= ~shifting;
      end
    end
  end

  // Pins routed to the emulation tap as strobes plus sampled levels
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_emu_tck_rise <= 1'b0;
      o_emu_tck_fall <= 1'b0;
      o_emu_tms <= 1'b1;
      o_emu_tdi <= 1'b1;
    end else begin
      o_emu_tck_rise <= trst_n_s & o_emu_selected & tck_rise;
      o_emu_tck_fall <= trst_n_s & o_emu_selected & tck_fall;
      if (trst_n_s && o_emu_selected && tck_rise) begin
        o_emu_tms <= tms_s;
        o_emu_tdi <= tdi_s;
      end
    end
  end

  assign o_scan_active = ~o_tdo_oe_n;

  // Pull-ups: a set inhibit bit turns the pull-up off, except the reset pull-up while reset is low
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pu_reset_en <= 1'b1;
      o_pu_tms_en <= 1'b1;
      o_pu_tdi_en <= 1'b1;
      o_pu_tck_en <= 1'b1;
    end else begin
      // Forced on so a floating reset pin stays defined
      o_pu_reset_en <= ~i_pullup_inhibit_reg[`TP_PUI_RESET] | ~reset_n_s;
      o_pu_tms_en <= ~i_pullup_inhibit_reg[`TP_PUI_TMS];
      o_pu_tdi_en <= ~i_pullup_inhibit_reg[`TP_PUI_TDI];
      o_pu_tck_en <= ~i_pullup_inhibit_reg[`TP_PUI_TCK];
    end
  end

  // Reset entry: halt, read vector from ROM, branch
  test_port_pkg::boot_state_e boot;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      boot <= test_port_pkg::BOOT_HALT;
    end else if (!reset_n_s) begin
      boot <= test_port_pkg::BOOT_HALT;
    end else begin
      case (boot)
        test_port_pkg::BOOT_HALT: boot <= test_port_pkg::BOOT_FETCH;
        test_port_pkg::BOOT_FETCH: boot <= test_port_pkg::BOOT_RUN;
        test_port_pkg::BOOT_RUN: boot <= test_port_pkg::BOOT_RUN;
        default: boot <= test_port_pkg::BOOT_HALT;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cpu_halt <= 1'b1;
      o_vector_rd <= 1'b0;
      o_pc <= `TP_RESET_VECTOR_ADDR;
      o_pc_load <= 1'b0;
      o_boot_branch <= 1'b0;
    end else begin
      o_vector_rd <= 1'b0;
      o_pc_load <= 1'b0;
      o_boot_branch <= 1'b0;
      if (!reset_n_s) begin
        o_cpu_halt <= 1'b1;
        o_pc <= `TP_RESET_VECTOR_ADDR;
        o_pc_load <= 1'b1;
      end else if (boot == test_port_pkg::BOOT_HALT) begin
        o_vector_rd <= 1'b1;
      end else if (boot == test_port_pkg::BOOT_FETCH) begin
        // ROM answers in the same cycle as the read strobe
        o_pc <= i_rom_vector;
        o_pc_load <= 1'b1;
        o_boot_branch <= 1'b1;
        o_cpu_halt <= 1'b0;
      end
    end
  end

  assign o_vector_addr = `TP_RESET_VECTOR_ADDR;

endmodule

// ### core/test_port_map.svh
// Constants for the test port and reset entry block.
// Assumes inclusion by bare name from the core design files.
// Notes on behaviour
// - Reset asserted halts core, loads vector address
// - Release fetches ROM vector, branches to bootloader
// - Reset pull-up forced on while reset asserted
// - TMS sampled on rising test clock
// - TDI captured into selected register on rise
// - TDO changes only on falling test clock
// - TDO high impedance except while shifting, or while the emulation tap asks to drive it
// - TMS, TDI, TCK pull-ups follow inhibit bits
// - Scan control only while test reset high
// - Test reset rise latches emulation select
`ifndef TEST_PORT_MAP_SVH
`define TEST_PORT_MAP_SVH

// Reset vector location in ROM
`define TP_RESET_VECTOR_ADDR 24'hFFFF00
`define TP_PC_W 24

// Pull-up inhibit register layout, a set bit disables that pull-up
`define TP_PUI_W 4
`define TP_PUI_RESET 0
`define TP_PUI_TMS 1
`define TP_PUI_TDI 2
`define TP_PUI_TCK 3
`define TP_PUI_RESET_VAL 4'h0

// Instruction that selects the boundary register; others select bypass
`define TP_IR_BOUNDARY 32'h0
// Low two bits captured into the instruction register
`define TP_IR_CAPTURE_LOW 2'h1

`endif

// ### core/test_port_pkg.sv
// Types shared by the test port and reset entry block.
// Assumes nothing of its surroundings.
package test_port_pkg;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } tap_state_e;

  typedef enum logic [1:0] {
    BOOT_HALT, BOOT_FETCH, BOOT_RUN
  } boot_state_e;

endpackage

// ### tb/scan_ctrl_model.sv
// Behavioural scan controller driving test clock, mode, data and test reset.
// Assumes i_clk is the bench clock; the test clock is i_clk divided by 20.
module scan_ctrl_model (
  // Clock
  input wire logic i_clk,
  // Scan pins
  input wire logic i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_test_rst_n,
  output logic o_emu_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  int div = 0;

  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
    o_test_rst_n = 1'b0;
    o_emu_sel = 1'b0;
  end

  // Free-running, equal halves of 40 ns
  always @(posedge i_clk) begin
    div <= (div == 9) ? 0 : div + 1;
    if (div == 9) begin
      o_tck <= ~o_tck;
    end
  end

  // Change mode and data after a fall, read tdo at the next rise
  task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
    @(negedge o_tck);
    @(posedge i_clk);
    o_tms <= tms_v;
    o_tdi <= tdi_v;
    @(posedge o_tck);
    tdo_v = i_tdo;
  endtask

  task automatic walk(input logic [7:0] seq, input int n);
    logic unused;
    for (int i = 0; i < n; i++) begin
      step(seq[i], 1'b1, unused);
    end
  endtask

  // Least significant bit first; the last bit leaves the shift state
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = 32'h0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
  endtask

  // Select pin changes in the same cycle as the test reset edge, then both are held
  task automatic drive_reset(input logic rst_v, input logic emu_v);
    @(posedge i_clk);
    o_test_rst_n <= rst_v;
    o_emu_sel <= emu_v;
    repeat (8) @(posedge i_clk);
  endtask
endmodule

// ### tb/test_port_and_reset_entry_tb.sv
// Self-checking bench for the test port and reset entry block.
// Assumes the checker binds itself and the controller model drives the scan pins.
`include "test_port_map.svh"
module test_port_and_reset_entry_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [3:0] inh; logic [3:0] pu;} row_s;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_reset_pin_n = 1'b0;
  logic [3:0] i_pullup_inhibit_reg = 4'h0;
  logic [7:0] i_bsr_capture = 8'h3C;
  logic i_emu_tdo = 1'b0;
  logic i_emu_tdo_drive = 1'b0;
  logic [23:0] i_rom_vector = 24'h12345A;
  logic i_tck, i_tms, i_tdi, i_test_rst_n, i_emulation_select_pin, tdo_line, bit_seen;
  logic o_tdo, o_tdo_oe_n, o_pu_reset_en, o_pu_tms_en, o_pu_tdi_en, o_pu_tck_en;
  logic o_emu_selected, o_emu_tck_rise, o_emu_tck_fall, o_emu_tms, o_emu_tdi, o_scan_active;
  logic o_cpu_halt, o_vector_rd, o_pc_load, o_boot_branch;
  logic [7:0] o_bsr_update;
  logic [3:0] o_instruction;
  logic [23:0] o_vector_addr, o_pc;
  logic [31:0] got;
  int errors = 0;
  int checked = 0;
  row_s rows [4] = '{'{4'h0, 4'hF}, '{4'hF, 4'h0}, '{4'h5, 4'hA}, '{4'hA, 4'h5}};

  always #2 i_clk = ~i_clk;
  // Undriven line shows no stale value
  assign tdo_line = o_tdo_oe_n ? ~o_tdo : o_tdo;

  test_port_and_reset_entry #(.IR_W(4), .BSR_W(8)) u_test_port_and_reset_entry (.*);
  scan_ctrl_model u_scan_ctrl_model (.i_clk, .i_tdo(tdo_line), .o_tck(i_tck), .o_tms(i_tms),
    .o_tdi(i_tdi), .o_test_rst_n(i_test_rst_n), .o_emu_sel(i_emulation_select_pin));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Whole run is under 3000 cycles; margin for slow scans
  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    check("halt", o_cpu_halt, 1'h1);
    check("pc", o_pc, `TP_RESET_VECTOR_ADDR);
    i_reset_pin_n <= 1'b1;
    for (int i = 0; i < 40 && o_boot_branch !== 1'b1; i++) begin
      @(posedge i_clk);
      #1;
    end
    check("branch", o_boot_branch, 1'h1);
    check("pc", o_pc, i_rom_vector);
    check("halt", o_cpu_halt, 1'h0);
    check("vec_addr", o_vector_addr, `TP_RESET_VECTOR_ADDR);
    foreach (rows[i]) begin
      @(posedge i_clk);
      i_pullup_inhibit_reg <= rows[i].inh;
      repeat (3) @(posedge i_clk);
      check("pullups", {o_pu_tck_en, o_pu_tdi_en, o_pu_tms_en, o_pu_reset_en}, rows[i].pu);
    end
    // Reset with every pull-up inhibited
    @(posedge i_clk);
    i_pullup_inhibit_reg <= 4'hF;
    i_reset_pin_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    check("pu_reset", o_pu_reset_en, 1'h1);
    check("halt", o_cpu_halt, 1'h1);
    check("pc_load", o_pc_load, 1'h1);
    check("pc", o_pc, `TP_RESET_VECTOR_ADDR);
    i_reset_pin_n <= 1'b1;
    i_pullup_inhibit_reg <= 4'h0;
    // Boundary tap: load the boundary instruction, then scan the chain
    u_scan_ctrl_model.drive_reset(1'b0, 1'b0);
    u_scan_ctrl_model.drive_reset(1'b1, 1'b0);
    check("emu_sel", o_emu_selected, 1'h0);
    // Bypass path before any instruction is loaded: one stage of delay
    u_scan_ctrl_model.walk(8'h02, 4);
    u_scan_ctrl_model.shift(4, 32'h5, got);
    check("bypass", got[3:0], 4'hA);
    u_scan_ctrl_model.walk(8'h1F, 5);
    u_scan_ctrl_model.walk(8'h06, 5);
    u_scan_ctrl_model.shift(4, 32'h0, got);
    check("ir_out", got[1:0], 2'h1);
    u_scan_ctrl_model.walk(8'h01, 2);
    repeat (5) @(posedge i_clk);
    check("instruction", o_instruction, 4'h0);
    check("oe_idle", o_tdo_oe_n, 1'h1);
    check("scan_idle", o_scan_active, 1'h0);
    u_scan_ctrl_model.walk(8'h01, 3);
    u_scan_ctrl_model.shift(8, 32'hA5, got);
    check("dr_out", got[7:0], i_bsr_capture);
    u_scan_ctrl_model.walk(8'h01, 2);
    repeat (5) @(posedge i_clk);
    check("bsr_update", o_bsr_update, 8'hA5);
    // Test reset low drops the loaded instruction
    u_scan_ctrl_model.drive_reset(1'b0, 1'b1);
    check("instr_off", o_instruction, 4'hF);
    check("oe_off", o_tdo_oe_n, 1'h1);
    // Emulation tap
    i_emu_tdo <= 1'b1;
    i_emu_tdo_drive <= 1'b1;
    u_scan_ctrl_model.drive_reset(1'b1, 1'b1);
    check("emu_sel", o_emu_selected, 1'h1);
    u_scan_ctrl_model.step(1'b1, 1'b0, bit_seen);
    repeat (5) @(posedge i_clk);
    check("emu_tms", o_emu_tms, 1'h1);
    check("emu_tdi", o_emu_tdi, 1'h0);
    u_scan_ctrl_model.step(1'b0, 1'b1, bit_seen);
    check("emu_tdo", bit_seen, 1'h1);
    wrap_up();
  end
endmodule

// ### tb/test_port_chk.sv
// Concurrent checks on the test port and reset entry block.
// Assumes binding to the top module; sees only its ports.
`include "test_port_map.svh"
module test_port_chk #(
  parameter int IR_W = 4,
  parameter int BSR_W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Pins
  input wire logic i_reset_pin_n,
  input wire logic i_tck,
  input wire logic i_test_rst_n,
  input wire logic i_emulation_select_pin,
  input wire logic [`TP_PUI_W-1:0] i_pullup_inhibit_reg,
  input wire logic [`TP_PC_W-1:0] i_rom_vector,
  // Outputs watched
  input wire logic o_tdo,
  input wire logic o_tdo_oe_n,
  input wire logic o_scan_active,
  input wire logic o_pu_reset_en,
  input wire logic o_pu_tms_en,
  input wire logic o_pu_tdi_en,
  input wire logic o_pu_tck_en,
  input wire logic o_emu_selected,
  input wire logic o_emu_tck_rise,
  input wire logic o_emu_tck_fall,
  input wire logic [IR_W-1:0] o_instruction,
  input wire logic o_cpu_halt,
  input wire logic o_vector_rd,
  input wire logic [`TP_PC_W-1:0] o_vector_addr,
  input wire logic [`TP_PC_W-1:0] o_pc,
  input wire logic o_pc_load,
  input wire logic o_boot_branch
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // Six cycles covers the pin synchroniser and the output register
  sequence pin_low_held;
    !i_reset_pin_n [*6];
  endsequence
  sequence branch_step;
    ##1 o_boot_branch && o_pc_load && !o_cpu_halt && o_pc == $past(i_rom_vector);
  endsequence
  sequence emu_rise(logic v);
    $rose(i_test_rst_n) && i_emulation_select_pin == v
      ##1 (i_test_rst_n && i_emulation_select_pin == v) [*4];
  endsequence

  a_halt_on_reset:
  assert property (pin_low_held |-> o_cpu_halt && o_pc_load && o_pc == `TP_RESET_VECTOR_ADDR)
    else $error("core not halted at vector during reset");
  a_vector_fetch:
  assert property (o_vector_rd |-> o_vector_addr == `TP_RESET_VECTOR_ADDR ##0 branch_step)
    else $error("vector fetch not followed by branch");
  a_branch_cause:
  assert property (o_boot_branch |-> $past(o_vector_rd))
    else $error("branch without vector read");
  a_pullup_forced:
  assert property (pin_low_held |-> o_pu_reset_en)
    else $error("reset pull-up off during reset");
  a_pullup_follow:
  assert property ({o_pu_tck_en, o_pu_tdi_en, o_pu_tms_en} == ~$past(i_pullup_inhibit_reg[3:1]))
    else $error("scan pull-ups do not follow inhibit bits");
  a_tdo_on_fall:
  assert property (i_test_rst_n && $changed(o_tdo) |-> !$past(i_tck, 2) && !$past(i_tck, 3))
    else $error("tdo changed away from a test clock fall");
  a_oe_on_fall:
  assert property ($fell(o_tdo_oe_n) |-> !$past(i_tck, 2) && !$past(i_tck, 3))
    else $error("tdo driver enabled away from a test clock fall");
  a_scan_flag:
  assert property (o_scan_active == !o_tdo_oe_n)
    else $error("scan flag disagrees with tdo enable");
  a_scan_held_off:
  assert property (!i_test_rst_n [*4] |-> o_tdo_oe_n && &o_instruction && !o_emu_tck_rise)
    else $error("scan logic active while test reset low");
  a_emu_latch_hi:
  assert property (emu_rise(1'b1) |-> o_emu_selected)
    else $error("emulation tap not selected");
  a_emu_latch_lo:
  assert property (emu_rise(1'b0) |-> !o_emu_selected)
    else $error("boundary tap not selected");
  a_emu_strobe:
  assert property (o_emu_tck_rise |-> o_emu_selected)
    else $error("emulation strobe while boundary tap selected");
  a_emu_fall_strobe:
  assert property (o_emu_tck_fall |-> o_emu_selected && $past(i_tck, 4) && !$past(i_tck, 3))
    else $error("emulation fall strobe away from a test clock fall");
endmodule

bind test_port_and_reset_entry test_port_chk #(.IR_W(IR_W), .BSR_W(BSR_W)) u_test_port_chk (
  .i_clk, .i_arst_n, .i_reset_pin_n, .i_tck, .i_test_rst_n, .i_emulation_select_pin,
  .i_pullup_inhibit_reg, .i_rom_vector, .o_tdo, .o_tdo_oe_n, .o_scan_active, .o_pu_reset_en,
  .o_pu_tms_en, .o_pu_tdi_en, .o_pu_tck_en, .o_emu_selected, .o_emu_tck_rise, .o_emu_tck_fall,
  .o_instruction, .o_cpu_halt, .o_vector_rd, .o_vector_addr, .o_pc, .o_pc_load, .o_boot_branch
);
